//--- ect_pkg.sv
// Purpose: Shared constants and types for the array configuration and timebase block
// Assumes: AXI4-Lite register access, 32-bit data, one register per word
// Notes:   Offsets are byte addresses
package ect_pkg;

   localparam int ADDR_W      = 12;
   localparam int ARRAY_DEPTH = 512;
   localparam int IDX_W       = 9;
   localparam int CFG_W       = 5;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_ARRAY_END = 12'h800;
   localparam logic [ADDR_W-1:0] ADDR_NVCFG     = 12'h800;
   localparam logic [ADDR_W-1:0] ADDR_NVDIV     = 12'h804;
   localparam logic [ADDR_W-1:0] ADDR_ACTCFG    = 12'h808;
   localparam logic [ADDR_W-1:0] ADDR_ACTDIV    = 12'h80C;
   localparam logic [ADDR_W-1:0] ADDR_SYSCFG2   = 12'h810;
   localparam logic [ADDR_W-1:0] ADDR_OPCTL     = 12'h814;

   // Field positions and masks
   localparam int PROT_BIT = 4;
   localparam int LOCK_BIT = 15;
   localparam int SEL_BIT  = 0;
   localparam logic [CFG_W-1:0] CFG_BLANK  = 5'h1F;
   localparam logic [7:0]       BYTE_BLANK = 8'hFF;
   localparam logic [15:0]      DIV_BLANK  = 16'hFFFF;
   localparam logic [15:0]      DIV_MASK   = 16'h87FF;
   localparam logic [15:0]      DIV_RESET  = 16'h0000;
   localparam logic [15:0]      DIV_ONE    = 16'h0001;
   localparam logic [IDX_W-1:0] SECURE_BASE = 9'h0F0;
   localparam logic [IDX_W-1:0] SECURE_LAST = 9'h0FF;

   // Alteration targets beyond the array
   localparam logic [9:0] TGT_NVCFG = 10'h200;
   localparam logic [9:0] TGT_DIVH  = 10'h201;
   localparam logic [9:0] TGT_DIVL  = 10'h202;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] WORD_ZERO  = 32'h0;

   typedef enum logic [1:0]
   {
      OP_NONE  = 2'h0,
      OP_PROG  = 2'h1,
      OP_ERASE = 2'h2,
      OP_BULK  = 2'h3
   } ect_op_t;

   // Layout of a write to the operation control register
   typedef struct packed
   {
      logic [5:0] rsvdHi;
      ect_op_t    op;
      logic [5:0] rsvdMid;
      logic [9:0] target;
      logic [7:0] data;
   } ect_opreq_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } ect_state_t;

endpackage

//--- ect_config_timebase.sv
// Purpose: Nonvolatile array with shadowed configuration and a 35 us timebase divider
// Assumes: clk 10 MHz; crystalRefClk is asynchronous; porN marks power-on only
// Notes:   Array and nonvolatile copies keep their contents across rst_n
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - 512-byte array at a fixed window, each byte readable by software.
// - An internal pump enable powers alteration; no external high voltage needed.
// - 5-bit config and 16-bit divider copies altered like array bytes.
// - Every system reset copies nonvolatile registers into their shadows.
// - Shadows are software read/write and alone set active configuration.
// - Config byte shadow drives security and block protection in effect.
// - Divider high and low bytes each load their matching shadow byte.
// - Alterations are timed by the timebase tick of 35 us.
// - One config bit picks crystal reference or bus clock for timebase.
// - Timebase divides the selected reference by the 16-bit shadow divider.
// - Protection applies after reset and on each read of nonvolatile config; a config shadow write in the same cycle wins over the read.
// - Lock bit at zero keeps the reset-loaded masked divider and freezes divider copies.
module ect_config_timebase
   import ect_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               porN,
   input  wire logic               crystalRefClk,
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output var  logic               s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output var  logic               s_axi_wready,
   output var  logic [1:0]         s_axi_bresp,
   output var  logic               s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output var  logic               s_axi_arready,
   output var  logic [31:0]        s_axi_rdata,
   output var  logic [1:0]         s_axi_rresp,
   output var  logic               s_axi_rvalid,
   input  wire logic               s_axi_rready,
   output var  logic               timebaseTick,
   output var  logic               pumpOn
);

   logic             rstSync1;
   logic             rstSync2;
   logic             porSync1;
   logic             porSync2;
   logic             xSync1;
   logic             xSync2;
   logic             xPrev;
   logic             loadPend;
   logic [7:0]       memArray [ARRAY_DEPTH];
   logic [CFG_W-1:0] nvCfg;
   logic [15:0]      nvDiv;
   logic [CFG_W-1:0] actCfg;
   logic [15:0]      actDiv;
   logic             divLocked;
   logic             clkSel;
   logic [15:0]      tbCount;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0]      wData;
   logic [3:0]       wStrb;
   logic             awHeld;
   logic             wHeld;
   ect_state_t       state;
   ect_opreq_t       pend;
   logic             opErr;

   // Reset and power-on release synchronisers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end
      else
      begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   always_ff @(posedge clk or negedge porN)
   begin
      if (!porN)
      begin
         porSync1 <= 1'b0;
         porSync2 <= 1'b0;
      end
      else
      begin
         porSync1 <= 1'b1;
         porSync2 <= porSync1;
      end
   end

   // Crystal reference sampled into the bus clock domain
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         xSync1 <= 1'b0;
         xSync2 <= 1'b0;
         xPrev  <= 1'b0;
      end
      else
      begin
         xSync1 <= crystalRefClk;
         xSync2 <= xSync1;
         xPrev  <= xSync2;
      end
   end

   // Bus decode
   wire doWrite  = awHeld && wHeld && !s_axi_bvalid;
   wire doRead   = s_axi_arvalid && s_axi_arready;
   wire wrArray  = awAddr < ADDR_ARRAY_END;
   wire rdArray  = s_axi_araddr < ADDR_ARRAY_END;
   wire wrActCfg = doWrite && awAddr == ADDR_ACTCFG && wStrb[0];
   wire wrActDiv = doWrite && awAddr == ADDR_ACTDIV;
   wire wrSys    = doWrite && awAddr == ADDR_SYSCFG2 && wStrb[0];
   wire wrOp     = doWrite && awAddr == ADDR_OPCTL;
   wire wrMapped = wrArray || awAddr == ADDR_NVCFG
                 || awAddr == ADDR_NVDIV || awAddr == ADDR_ACTCFG
                 || awAddr == ADDR_ACTDIV || awAddr == ADDR_SYSCFG2
                 || awAddr == ADDR_OPCTL;
   wire rdNvCfg  = doRead && s_axi_araddr == ADDR_NVCFG;
   wire rdMapped = rdArray || s_axi_araddr == ADDR_NVCFG
                 || s_axi_araddr == ADDR_NVDIV || s_axi_araddr == ADDR_ACTCFG
                 || s_axi_araddr == ADDR_ACTDIV || s_axi_araddr == ADDR_SYSCFG2
                 || s_axi_araddr == ADDR_OPCTL;

   wire [IDX_W-1:0] rdIdx = s_axi_araddr[IDX_W+1:2];
   wire [31:0] rdWord =
      rdArray ? {24'h0, memArray[rdIdx]} :
      s_axi_araddr == ADDR_NVCFG   ? {27'h0, nvCfg} :
      s_axi_araddr == ADDR_NVDIV   ? {16'h0, nvDiv} :
      s_axi_araddr == ADDR_ACTCFG  ? {27'h0, actCfg} :
      s_axi_araddr == ADDR_ACTDIV  ? {16'h0, actDiv} :
      s_axi_araddr == ADDR_SYSCFG2 ? {31'h0, clkSel} :
      s_axi_araddr == ADDR_OPCTL   ? {30'h0, opErr, pumpOn} :
      WORD_ZERO;

   // Write channels: address and data taken in either order
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= '0;
         wData         <= WORD_ZERO;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         awHeld       <= 1'b0;
         wHeld        <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld        <= 1'b1;
            awAddr        <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld        <= 1'b1;
            wData        <= s_axi_wdata;
            wStrb        <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read channel
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= WORD_ZERO;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (doRead)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdWord;
         s_axi_rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Active configuration shadows
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         loadPend  <= 1'b1;
         actCfg    <= CFG_BLANK;
         actDiv    <= DIV_RESET;
         divLocked <= 1'b0;
         clkSel    <= 1'b0;
      end
      else
      begin
         loadPend <= 1'b0;
         if (loadPend)
         begin
            actCfg    <= nvCfg;
            actDiv    <= nvDiv & DIV_MASK;
            divLocked <= !nvDiv[LOCK_BIT];
         end
         else
         begin
            if (wrActCfg)
               actCfg <= wData[CFG_W-1:0];
            else if (rdNvCfg)
               actCfg <= nvCfg;
            if (wrActDiv && !divLocked)
            begin
               if (wStrb[1])
                  actDiv[15:8] <= wData[15:8] & DIV_MASK[15:8];
               if (wStrb[0])
                  actDiv[7:0] <= wData[7:0];
            end
         end
         if (wrSys)
            clkSel <= wData[SEL_BIT];
      end
   end

   wire refEn   = clkSel ? (xSync2 && !xPrev) : 1'b1;
   wire tbWrap  = refEn && actDiv != DIV_RESET && tbCount >= actDiv - DIV_ONE;

   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         tbCount      <= DIV_RESET;
         timebaseTick <= 1'b0;
      end
      else
      begin
         timebaseTick <= tbWrap;
         if (tbWrap)
            tbCount <= DIV_RESET;
         else if (refEn)
            tbCount <= tbCount + DIV_ONE;
      end
   end

   // Request checks against active protection
   ect_opreq_t req;
   assign req = ect_opreq_t'(wData);
   wire reqArr  = !req.target[IDX_W];
   wire [IDX_W-1:0] reqIdx = req.target[IDX_W-1:0];
   wire secArmed = !actCfg[PROT_BIT];
   wire blkProt  = actCfg[reqIdx[IDX_W-1:IDX_W-2]];
   wire secByte  = reqIdx >= SECURE_BASE && reqIdx <= SECURE_LAST;
   wire reqOk =
      req.op == OP_BULK  ? !secArmed && actCfg[3:0] == 4'h0 :
      req.op == OP_NONE  ? 1'b0 :
      reqArr             ? !blkProt && !(secArmed && secByte) :
      req.target == TGT_NVCFG ? !secArmed :
      (req.target == TGT_DIVH || req.target == TGT_DIVL) ? !divLocked :
      1'b0;

   // Alteration engine
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         state  <= ST_IDLE;
         pend   <= '0;
         opErr  <= 1'b0;
         pumpOn <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (wrOp && reqOk)
               begin
                  pend   <= req;
                  opErr  <= 1'b0;
                  pumpOn <= 1'b1;
                  state  <= ST_WAIT;
               end
               else if (wrOp)
                  opErr <= 1'b1;
            end
            ST_WAIT:
            begin
               if (wrOp)
                  opErr <= 1'b1;
               if (timebaseTick)
               begin
                  pumpOn <= 1'b0;
                  state  <= ST_IDLE;
               end
            end
            default:
            begin
               state  <= ST_IDLE;
               pumpOn <= 1'b0;
            end
         endcase
      end
   end

   wire commit = state == ST_WAIT && timebaseTick;
   wire [7:0] oldByte =
      pend.target == TGT_NVCFG ? {3'h7, nvCfg} :
      pend.target == TGT_DIVH  ? nvDiv[15:8] :
      pend.target == TGT_DIVL  ? nvDiv[7:0] :
      memArray[pend.target[IDX_W-1:0]];
   // Programming only clears bits; erase returns them to one
   wire [7:0] newByte = pend.op == OP_PROG ? (oldByte & pend.data) : BYTE_BLANK;

   always_ff @(posedge clk)
   begin
      if (commit && pend.op == OP_BULK)
      begin
         for (int i = 0; i < ARRAY_DEPTH; i++)
            memArray[i] <= BYTE_BLANK;
      end
      else if (commit && !pend.target[IDX_W])
         memArray[pend.target[IDX_W-1:0]] <= newByte;
   end

   always_ff @(posedge clk or negedge porSync2)
   begin
      if (!porSync2)
      begin
         nvCfg <= CFG_BLANK;
         nvDiv <= DIV_BLANK;
      end
      else if (commit)
      begin
         if (pend.target == TGT_NVCFG)
            nvCfg <= newByte[CFG_W-1:0];
         if (pend.target == TGT_DIVH)
            nvDiv[15:8] <= newByte;
         if (pend.target == TGT_DIVL)
            nvDiv[7:0] <= newByte;
      end
   end

endmodule

`default_nettype wire

//--- ect_config_timebase_sva.sv
// Purpose: Port-level checks for the config and timebase block
// Assumes: One clock domain, rst_n active low
// Notes:   Bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module ect_config_timebase_sva
   import ect_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        timebaseTick,
   input wire logic        pumpOn
);
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   wr_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   b_close_a: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write answer not closed");
   r_close_a: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not closed");
   slverr_zero_a: assert property (
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == WORD_ZERO)
      else $error("error read carries data");
   pump_end_a: assert property (
      $fell(pumpOn) |-> timebaseTick || $past(timebaseTick))
      else $error("pump stopped off the tick");
   reset_idle_a: assert property (
      $rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !pumpOn && !timebaseTick)
      else $error("outputs busy after reset");
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the config and timebase block
// Assumes: Crystal reference period is seven bus cycles
// Notes:   Divider kept small so alterations finish fast
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import ect_pkg::*;
;
   logic              clk, rst_n, porN, xclk;
   logic              awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, tick, pump;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, lfsr, got, rsp;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   int                miscompares, cmpCount, cyc, n, divRef;

   always #50 clk = ~clk;

   initial
   begin
      xclk = 1'b0;
      #20;
      forever #350 xclk = ~xclk;
   end

   ect_config_timebase u_dut
   (
      .clk(clk), .rst_n(rst_n), .porN(porN), .crystalRefClk(xclk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr_),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .timebaseTick(tick), .pumpOn(pump)
   );

   function automatic logic [31:0] nextRand(input logic [31:0] s);
      nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] expDiv(input logic [15:0] v);
      expDiv = {16'h0000, v & DIV_MASK};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmpCount++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic endOfTest;
      $display("compares=%0d mismatches=%0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         miscompares++;
         endOfTest();
      end
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      {awv, wv, br} <= 3'h7;
      tb = 1'b0;
      while (!tb)
      begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr_;
         tb = bv & br;
         rsp = {30'h0, bresp};
         @(posedge clk);
         if (ta)
            awv <= 1'b0;
         if (tw)
            wv <= 1'b0;
      end
      br <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      logic ta, t;
      @(posedge clk);
      araddr <= a;
      {arv, rr} <= 2'h3;
      t = 1'b0;
      while (!t)
      begin
         @(negedge clk);
         ta = arv & arr;
         t = rv & rr;
         got = rdata;
         rsp = {30'h0, rresp};
         @(posedge clk);
         if (ta)
            arv <= 1'b0;
      end
      rr <= 1'b0;
   endtask

   // Alteration request, then poll until the pump is off
   task automatic op(input ect_op_t o, input logic [9:0] t, input logic [7:0] d);
      ect_opreq_t q;
      q = '{rsvdHi: 6'h00, op: o, rsvdMid: 6'h00, target: t, data: d};
      wr(ADDR_OPCTL, q);
      do
         rd(ADDR_OPCTL);
      while (got[0] !== 1'b0);
   endtask

   // Bus cycles between two successive ticks
   task automatic gap(output int c);
      c = 0;
      do
         @(negedge clk);
      while (tick !== 1'b1);
      do
      begin
         @(negedge clk);
         c++;
      end
      while (tick !== 1'b1);
   endtask

   initial
   begin
      clk = 1'b0;
      {rst_n, porN, awv, wv, br, arv, rr} = 7'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      wstrb = 4'hF;
      lfsr = 32'h25;
      repeat (3) @(posedge clk);
      {rst_n, porN} <= 2'h3;
      repeat (3) @(posedge clk);
      rd(ADDR_NVCFG);
      chk(got, {27'h0, CFG_BLANK});
      rd(ADDR_NVDIV);
      chk(got, {16'h0, DIV_BLANK});
      rd(ADDR_ACTCFG);
      chk(got, {27'h0, CFG_BLANK});
      rd(ADDR_ACTDIV);
      chk(got, expDiv(DIV_BLANK));
      rd(12'hFFC);
      chk(rsp, {30'h0, RESP_SLVERR});
      wr(12'h818, 32'h0);
      chk(rsp, {30'h0, RESP_SLVERR});
      repeat (4)
      begin
         lfsr = nextRand(lfsr);
         wr(ADDR_ACTDIV, lfsr);
         rd(ADDR_ACTDIV);
         chk(got, expDiv(lfsr[15:0]));
      end
      wstrb <= 4'h1;
      wr(ADDR_ACTDIV, 32'hFFFF);
      wstrb <= 4'hF;
      rd(ADDR_ACTDIV);
      chk(got, expDiv({lfsr[15:8], 8'hFF}));
      wr(ADDR_ACTDIV, 32'h4);
      op(OP_PROG, 10'h005, 8'h00);
      chk(got, 32'h2);
      wr(ADDR_ACTCFG, 32'h10);
      rd(ADDR_ACTCFG);
      chk(got, 32'h10);
      op(OP_BULK, 10'h000, 8'h00);
      chk(got, 32'h0);
      rd(12'h014);
      chk(got, {24'h0, BYTE_BLANK});
      rd(12'h7FC);
      chk(got, {24'h0, BYTE_BLANK});
      lfsr = nextRand(lfsr);
      op(OP_PROG, 10'h005, lfsr[7:0]);
      rd(12'h014);
      chk(got, {24'h0, lfsr[7:0]});
      // Security armed, no block protected
      wr(ADDR_ACTCFG, 32'h0);
      op(OP_PROG, 10'h0F0, 8'h00);
      chk(got, 32'h2);
      op(OP_BULK, 10'h000, 8'h00);
      chk(got, 32'h2);
      op(OP_NONE, 10'h005, 8'h00);
      chk(got, 32'h2);
      op(OP_PROG, 10'h1F0, 8'h00);
      chk(got, 32'h0);
      rd(12'h7C0);
      chk(got, 32'h0);
      op(OP_ERASE, 10'h005, 8'h00);
      rd(12'h014);
      chk(got, {24'h0, BYTE_BLANK});
      rd(ADDR_NVCFG);
      rd(ADDR_ACTCFG);
      chk(got, {27'h0, CFG_BLANK});
      op(OP_PROG, TGT_NVCFG, 8'hF0);
      rd(ADDR_NVCFG);
      chk(got, 32'h10);
      rd(ADDR_ACTCFG);
      chk(got, 32'h10);
      gap(n);
      chk(n, 4);
      wr(ADDR_SYSCFG2, 32'h1);
      gap(n);
      chk(n, 28);
      wr(ADDR_SYSCFG2, 32'h0);
      divRef = $rtoi(10.0e6 * 35.0e-6 + 0.5);
      wr(ADDR_ACTDIV, divRef);
      gap(n);
      chk(n, divRef);
      op(OP_PROG, TGT_DIVH, 8'h7F);
      rd(ADDR_NVDIV);
      chk(got, 32'h7FFF);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_ACTDIV);
      chk(got, expDiv(16'h7FFF));
      wr(ADDR_ACTDIV, 32'h0123);
      rd(ADDR_ACTDIV);
      chk(got, expDiv(16'h7FFF));
      op(OP_PROG, TGT_DIVL, 8'h00);
      chk(got, 32'h2);
      endOfTest();
   end
endmodule

bind ect_config_timebase ect_config_timebase_sva u_sva
(
   .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timebaseTick, .pumpOn
);
`default_nettype wire
